// *** common/reiu_params.svh ***
// constants of the reset and interrupt exception unit
`ifndef REIU_PARAMS_SVH
`define REIU_PARAMS_SVH

// ----------
// register offsets (low address byte)
// ----------
`define REIU_OFS_EDGE_SEL 8'hF2
`define REIU_OFS_ENABLE1 8'hF3
`define REIU_OFS_ENABLE2 8'hF4
`define REIU_OFS_REQUEST1 8'hF6
`define REIU_OFS_REQUEST2 8'hF7
`define REIU_OFS_WAKE_REQ 8'hF9

// ----------
// reset values and fixed read bits
// ----------
`define REIU_EDGE_SEL_FIXED 3'h7
`define REIU_REQUEST1_FIXED 3'h1
`define REIU_POL_RESET 5'h00
`define REIU_EN_RESET 8'h00

// ----------
// enable register field positions
// ----------
`define REIU_EN1_WAKE 5
`define REIU_EN1_SERIAL1 6
`define REIU_EN1_TMA 7
`define REIU_EN2_TMB 0
`define REIU_EN2_TMC 1
`define REIU_EN2_TFL 2
`define REIU_EN2_TFH 3
`define REIU_EN2_TMG 4
`define REIU_EN2_SERIAL2 5
`define REIU_EN2_ADC 6
`define REIU_EN2_DIRECT 7

// ----------
// vectors and timing
// ----------
`define REIU_VEC_RESET 5'h00
`define REIU_VEC_FIRST_IRQ 5'h04
`define REIU_NUM_GROUPS 17
`define REIU_NUM_EDGE_PINS 5
`define REIU_NUM_WAKE_PINS 8
`define REIU_RELEASE_CLOCKS 8192
`define REIU_INIT_HOLD_CLOCKS 10

`endif

// *** common/reiu_pkg.sv ***
// types of the reset and interrupt exception unit
package reiu_pkg;

   // ----------
   // reset sequencer states
   // ----------
   typedef enum logic [4:0] {
      ST_RESET = 5'b00001,
      ST_WAIT_MODE = 5'b00010,
      ST_DELAY = 5'b00100,
      ST_FETCH = 5'b01000,
      ST_RUN = 5'b10000
   } reiu_state_e;

   // ----------
   // peripheral request lines, 20 in all
   // ----------
   typedef struct packed {
      logic serial1_done;
      logic tma_ovf;
      logic tmb_ovf;
      logic tmc_ovf;
      logic [1:0] tfl;
      logic [1:0] tfh;
      logic [1:0] tmg;
      logic [1:0] serial2;
      logic [5:0] serial3;
      logic adc_end;
      logic direct_xfer;
   } reiu_int_src_s;

   // ----------
   // exception request to the cpu core
   // ----------
   typedef struct packed {
      logic req;
      logic [4:0] num;
      logic [15:0] addr;
   } reiu_exc_s;

endpackage : reiu_pkg

// *** core/reiu_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module reiu_sync #(
   parameter int W = 1
) (
   input wire logic clk,              // system clock
   input wire logic rstn,             // async reset, active low
   input wire logic [W-1:0] pin_in,   // asynchronous pin levels
   input wire logic [W-1:0] rst_val,  // level shown after reset
   output logic [W-1:0] level_q       // filtered synchronous level
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic armed_q;

   initial begin
      if (W < 1) $error("reiu_sync: W must be at least 1");
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= armed_q ? pin_in : rst_val;
         s2_q <= armed_q ? s1_q : rst_val;
         s3_q <= armed_q ? s2_q : rst_val;
      end
   end

   // reset value is taken by a clocked load, never by the async branch
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         armed_q <= 1'b0;
      end else begin
         armed_q <= 1'b1;
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         level_q <= '0;
      end else if (!armed_q) begin
         level_q <= rst_val;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) level_q[i] <= s3_q[i];
         end
      end
   end
endmodule : reiu_sync

// *** core/reiu_exc_unit.sv ***
// reset sequencer and fixed-priority interrupt arbiter
//
// Functional notes
// RULE_01: reset outranks and aborts all interrupt handling
// RULE_02: interrupts start only at instruction boundary
// RULE_03: low init pin halts and holds reset
// RULE_04: outside holds init pin low ten clocks
// RULE_05: outside holds init pin until clock stable
// RULE_06: mode high: release starts reset handling
// RULE_07: mode low: wait mode rise, count 8192
// RULE_08: reset handling sets interrupt mask bit
// RULE_09: reset fetches start address from vector zero
// RULE_10: first instruction runs before any interrupt
// RULE_11: five edge, eight wakeup, twenty internal sources
// RULE_12: only highest-priority pending request is served
// RULE_13: mask blocks acceptance, flags still set
// RULE_14: each edge pin picks its own edge
// RULE_15: reset 0, edge pins 4-8, wakeup 9
// RULE_16: serial one 10, timers A,B,C 11-13
// RULE_17: timer FL 14, FH 15, G 16
// RULE_18: serial two 17, serial three 18
// RULE_19: polarity 0 falling, 1 rising edge
// RULE_20: request flags clear by writing zero only
// RULE_21: vectors one to three never issued
// RULE_22: pins synchronised, one flag set per edge
// RULE_23: converter end 19, direct transfer 20
`timescale 1ns/1ps
`include "reiu_params.svh"
module reiu_exc_unit import reiu_pkg::*; #(
   parameter int RELEASE_CLOCKS = `REIU_RELEASE_CLOCKS
) (
   input wire logic clk,                       // system clock 100 MHz
   input wire logic rstn,                      // power-on reset, active low
   input wire logic chip_init_pin_n,           // init pin, active low
   input wire logic mode_select_pin,           // mode select pin
   input wire logic [4:0] edge_request_pin,    // edge request pins
   input wire logic [7:0] wakeup_pin_n,        // wakeup pins, active low
   input wire reiu_int_src_s int_src,          // peripheral requests
   input wire logic insn_boundary,             // cpu between instructions
   input wire logic insn_done,                 // pulse: instruction retired
   input wire logic exc_ack,                   // pulse: cpu took exception
   input wire logic ccr_i_we,                  // cpu writes mask bit
   input wire logic ccr_i_wdata,               // new mask bit value
   input wire logic [7:0] reg_addr,            // register address
   input wire logic [7:0] reg_wdata,           // register write data
   input wire logic reg_wr,                    // write strobe
   input wire logic reg_rd,                    // read strobe
   output logic [7:0] reg_rdata_q,             // read data, next cycle
   output logic cpu_reset_q,                   // cpu and peripherals reset
   output logic ccr_i_q,                       // interrupt mask bit
   output reiu_exc_s exc_q                     // exception request
);
   localparam int CW = $clog2(RELEASE_CLOCKS + 1);
   localparam int NG = `REIU_NUM_GROUPS;

   initial begin
      if (RELEASE_CLOCKS < 1) $error("reiu_exc_unit: RELEASE_CLOCKS < 1");
      if (CW > 24) $error("reiu_exc_unit: RELEASE_CLOCKS too large");
   end

   // ----------
   // pin synchronisers
   // ----------
   logic init_n_s;
   logic mode_s;
   logic [4:0] edge_s;
   logic [7:0] wake_s;
   logic [14:0] pins_s;

   reiu_sync #(.W(15)) u_sync (  // [RULE_22]
      .clk(clk),
      .rstn(rstn),
      .pin_in({chip_init_pin_n, mode_select_pin, edge_request_pin,
               wakeup_pin_n}),
      .rst_val(15'h3FFF),  // init reads low: no early release
      .level_q(pins_s)
   );

   assign init_n_s = pins_s[14];
   assign mode_s = pins_s[13];
   assign edge_s = pins_s[12:8];
   assign wake_s = pins_s[7:0];

   // ----------
   // reset sequencer
   // ----------
   reiu_state_e state_q;
   reiu_state_e state_d;
   logic [CW-1:0] cnt_q;
   logic mode_prev_q;
   logic mode_rise;

   assign mode_rise = mode_s && !mode_prev_q;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_RESET: begin
            if (init_n_s) begin
               state_d = mode_s ? ST_FETCH : ST_WAIT_MODE;  // [RULE_06]
            end
         end
         ST_WAIT_MODE: begin
            if (mode_rise) state_d = ST_DELAY;  // [RULE_07]
         end
         ST_DELAY: begin
            if (cnt_q == CW'(RELEASE_CLOCKS - 1)) begin
               state_d = ST_FETCH;  // [RULE_07]
            end
         end
         ST_FETCH: begin
            if (exc_ack) state_d = ST_RUN;
         end
         ST_RUN: state_d = ST_RUN;
      endcase
      // a low init pin overrides every state at once
      if (!init_n_s) state_d = ST_RESET;  // [RULE_03] [RULE_01]
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) state_q <= ST_RESET;
      else state_q <= state_d;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) mode_prev_q <= 1'b1;
      else mode_prev_q <= mode_s;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) cnt_q <= '0;
      else if (state_q == ST_DELAY) cnt_q <= cnt_q + CW'(1);  // [RULE_07]
      else cnt_q <= '0;
   end

   // peripherals stay in reset until the vector fetch phase
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) cpu_reset_q <= 1'b1;
      else cpu_reset_q <= (state_d == ST_RESET) ||
                          (state_d == ST_WAIT_MODE) ||
                          (state_d == ST_DELAY);  // [RULE_03] [RULE_07]
   end

   // ----------
   // software registers
   // ----------
   logic [4:0] pol_q;
   logic [7:0] en1_q;
   logic [7:0] en2_q;
   logic [4:0] edge_flag_q;
   logic [7:0] wake_flag_q;
   logic [4:0] edge_prev_q;
   logic [7:0] wake_prev_q;
   logic [4:0] edge_evt;
   logic [7:0] wake_evt;
   logic wr_edge;
   logic wr_en1;
   logic wr_en2;
   logic wr_req1;
   logic wr_wake;
   logic periph_rst;

   assign periph_rst = cpu_reset_q;
   assign wr_edge = reg_wr && (reg_addr == `REIU_OFS_EDGE_SEL);
   assign wr_en1 = reg_wr && (reg_addr == `REIU_OFS_ENABLE1);
   assign wr_en2 = reg_wr && (reg_addr == `REIU_OFS_ENABLE2);
   assign wr_req1 = reg_wr && (reg_addr == `REIU_OFS_REQUEST1);
   assign wr_wake = reg_wr && (reg_addr == `REIU_OFS_WAKE_REQ);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pol_q <= `REIU_POL_RESET;
         en1_q <= `REIU_EN_RESET;
         en2_q <= `REIU_EN_RESET;
      end else if (periph_rst) begin
         pol_q <= `REIU_POL_RESET;  // [RULE_01] [RULE_08] [RULE_19]
         en1_q <= `REIU_EN_RESET;
         en2_q <= `REIU_EN_RESET;
      end else begin
         if (wr_edge) pol_q <= reg_wdata[4:0];  // [RULE_14]
         if (wr_en1) en1_q <= reg_wdata;
         if (wr_en2) en2_q <= reg_wdata;
      end
   end

   // edge detection on synchronised levels
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         edge_prev_q <= 5'h1F;
         wake_prev_q <= 8'hFF;
      end else begin
         edge_prev_q <= edge_s;
         wake_prev_q <= wake_s;
      end
   end

   always_comb begin
      for (int i = 0; i < `REIU_NUM_EDGE_PINS; i++) begin
         edge_evt[i] = pol_q[i] ? (edge_s[i] && !edge_prev_q[i])
                                : (!edge_s[i] && edge_prev_q[i]);  // [RULE_19]
      end
   end
   assign wake_evt = wake_prev_q & ~wake_s;  // [RULE_22]

   // set wins over a write-zero clear in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         edge_flag_q <= 5'h00;
         wake_flag_q <= 8'h00;
      end else if (periph_rst) begin
         edge_flag_q <= 5'h00;  // [RULE_01]
         wake_flag_q <= 8'h00;
      end else begin
         edge_flag_q <= (wr_req1 ? (edge_flag_q & reg_wdata[4:0])
                                 : edge_flag_q) | edge_evt;  // [RULE_20] [RULE_13]
         wake_flag_q <= (wr_wake ? (wake_flag_q & reg_wdata)
                                 : wake_flag_q) | wake_evt;  // [RULE_20] [RULE_13]
      end
   end

   // ----------------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------------
   logic [7:0] int_stat;

   assign int_stat = {int_src.direct_xfer, int_src.adc_end,
                      |int_src.serial2, |int_src.tmg, |int_src.tfh,
                      |int_src.tfl, int_src.tmc_ovf, int_src.tmb_ovf};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `REIU_OFS_EDGE_SEL: reg_rdata_q <= {`REIU_EDGE_SEL_FIXED, pol_q};
            `REIU_OFS_ENABLE1: reg_rdata_q <= en1_q;
            `REIU_OFS_ENABLE2: reg_rdata_q <= en2_q;
            `REIU_OFS_REQUEST1: reg_rdata_q <= {`REIU_REQUEST1_FIXED,
                                                edge_flag_q};
            `REIU_OFS_REQUEST2: reg_rdata_q <= int_stat;
            `REIU_OFS_WAKE_REQ: reg_rdata_q <= wake_flag_q;
            default: reg_rdata_q <= 8'h00;
         endcase
      end else begin
         reg_rdata_q <= 8'h00;
      end
   end

   // ----------------------------------------------------------------------
   // request grouping by vector, index 0 is vector 4
   // ----------------------------------------------------------------------
   logic [NG-1:0] grp;

   always_comb begin
      grp[4:0] = edge_flag_q & en1_q[4:0];  // [RULE_15] [RULE_11]
      grp[5] = (|wake_flag_q) && en1_q[`REIU_EN1_WAKE];  // [RULE_15]
      grp[6] = int_src.serial1_done && en1_q[`REIU_EN1_SERIAL1];  // [RULE_16]
      grp[7] = int_src.tma_ovf && en1_q[`REIU_EN1_TMA];  // [RULE_16]
      grp[8] = int_src.tmb_ovf && en2_q[`REIU_EN2_TMB];  // [RULE_16]
      grp[9] = int_src.tmc_ovf && en2_q[`REIU_EN2_TMC];  // [RULE_16]
      grp[10] = (|int_src.tfl) && en2_q[`REIU_EN2_TFL];  // [RULE_17]
      grp[11] = (|int_src.tfh) && en2_q[`REIU_EN2_TFH];  // [RULE_17]
      grp[12] = (|int_src.tmg) && en2_q[`REIU_EN2_TMG];  // [RULE_17]
      grp[13] = (|int_src.serial2) && en2_q[`REIU_EN2_SERIAL2];  // [RULE_18]
      // serial three gates its six events with its own enables
      grp[14] = |int_src.serial3;  // [RULE_18]
      grp[15] = int_src.adc_end && en2_q[`REIU_EN2_ADC];  // [RULE_23]
      grp[16] = int_src.direct_xfer && en2_q[`REIU_EN2_DIRECT];  // [RULE_23]
   end

   // ----------------------------------------------------------------------
   // fixed-priority pick, lowest index wins
   // ----------------------------------------------------------------------
   logic pend;
   logic [4:0] pick_num;

   always_comb begin
      pend = 1'b0;
      pick_num = `REIU_VEC_FIRST_IRQ;
      for (int i = NG - 1; i >= 0; i--) begin
         if (grp[i]) begin
            pend = 1'b1;
            pick_num = `REIU_VEC_FIRST_IRQ + 5'(i);  // [RULE_12] [RULE_21]
         end
      end
   end

   // ----------------------------------------------------------------------
   // mask bit, first-instruction hold and exception request
   // ----------------------------------------------------------------------
   logic hold_q;
   logic accept;

   // hold covers the stack pointer set-up that the first instruction does
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) hold_q <= 1'b1;
      else if (state_q != ST_RUN) hold_q <= 1'b1;  // [RULE_10]
      else if (insn_done) hold_q <= 1'b0;  // [RULE_10]
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) ccr_i_q <= 1'b1;
      else if (state_q != ST_RUN) ccr_i_q <= 1'b1;  // [RULE_08]
      else if (exc_ack) ccr_i_q <= 1'b1;
      else if (ccr_i_we) ccr_i_q <= ccr_i_wdata;
   end

   // no new request while one is outstanding: handling in progress
   assign accept = (state_q == ST_RUN) && insn_boundary && pend &&
                   !ccr_i_q && !hold_q && !exc_q.req;  // [RULE_02] [RULE_13]

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         exc_q <= '0;
      end else if (state_d == ST_RESET || state_d == ST_WAIT_MODE ||
                   state_d == ST_DELAY) begin
         exc_q <= '0;  // [RULE_01]
      end else if (state_d == ST_FETCH) begin
         exc_q.req <= 1'b1;  // [RULE_09]
         exc_q.num <= `REIU_VEC_RESET;
         exc_q.addr <= {10'h000, `REIU_VEC_RESET, 1'b0};  // [RULE_09]
      end else if (exc_ack) begin
         exc_q.req <= 1'b0;
      end else if (accept) begin
         exc_q.req <= 1'b1;  // [RULE_12]
         exc_q.num <= pick_num;
         exc_q.addr <= {10'h000, pick_num, 1'b0};  // [RULE_15]
      end
   end

endmodule : reiu_exc_unit

// *** tb/reiu_exc_sva.sv ***
// port checker for the exception unit
`timescale 1ns/1ps
module reiu_exc_sva import reiu_pkg::*; #(
   parameter int RELEASE_CLOCKS = 8192
) (
   input wire logic clk,             // system clock
   input wire logic rstn,            // async reset, active low
   input wire logic chip_init_pin_n, // init pin, active low
   input wire logic insn_boundary,   // cpu between instructions
   input wire logic insn_done,       // instruction retired
   input wire logic exc_ack,         // cpu took exception
   input wire logic cpu_reset_q,     // cpu held in reset
   input wire logic ccr_i_q,         // interrupt mask bit
   input wire reiu_exc_s exc_q       // exception request
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // ----------
   // first-instruction window
   // ----------
   // cleared by reset, so a re-reset vector is no violation
   logic hold_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) hold_q <= 1'b0;
      else if (insn_done || cpu_reset_q) hold_q <= 1'b0;
      else if (exc_q.req && exc_ack && exc_q.num == 5'h00) hold_q <= 1'b1;
   end
   // ----------
   // properties
   // ----------
   property p_vec_addr;
      exc_q.req |-> exc_q.addr == {10'h000, exc_q.num, 1'b0};
   endproperty
   a_vec_addr: assert property (p_vec_addr)
      else $error("bad vector address");
   property p_vec_legal;
      exc_q.req |-> exc_q.num <= 5'h14 && !(exc_q.num inside {[1:3]});
   endproperty
   a_vec_legal: assert property (p_vec_legal)
      else $error("reserved vector");
   property p_boundary;
      $rose(exc_q.req) && exc_q.num != 5'h00 |-> $past(insn_boundary);
   endproperty
   a_boundary: assert property (p_boundary)
      else $error("accepted mid-instruction");
   property p_masked;
      $rose(exc_q.req) && exc_q.num != 5'h00 |-> !$past(ccr_i_q);
   endproperty
   a_masked: assert property (p_masked)
      else $error("accepted while masked");
   property p_reset_vec;
      $fell(cpu_reset_q) |-> exc_q == {1'b1, 5'h00, 16'h0000} && ccr_i_q;
   endproperty
   a_reset_vec: assert property (p_reset_vec)
      else $error("bad reset release");
   property p_quiet_reset;
      cpu_reset_q |-> !exc_q.req;
   endproperty
   a_quiet_reset: assert property (p_quiet_reset)
      else $error("request in reset");
   property p_init_halts;
      !chip_init_pin_n [*8] |=> cpu_reset_q;
   endproperty
   a_init_halts: assert property (p_init_halts)
      else $error("init pin ignored");
   property p_release_pin;
      $fell(cpu_reset_q) |-> $past(chip_init_pin_n, 4);
   endproperty
   a_release_pin: assert property (p_release_pin)
      else $error("release with init pin low");
   property p_ack;
      exc_q.req && exc_ack |=> !exc_q.req && ccr_i_q;
   endproperty
   a_ack: assert property (p_ack)
      else $error("ack not honoured");
   property p_first;
      hold_q && !insn_done && !cpu_reset_q |=> !exc_q.req;
   endproperty
   a_first: assert property (p_first)
      else $error("early interrupt");
   c_reset: cover property ($fell(cpu_reset_q));
   c_wake: cover property ($rose(exc_q.req) && exc_q.num == 5'h09);
   c_ack: cover property (exc_q.req && exc_ack && exc_q.num != 5'h00);
endmodule : reiu_exc_sva

bind reiu_exc_unit reiu_exc_sva #(.RELEASE_CLOCKS(RELEASE_CLOCKS)) u_sva (
   .clk(clk),
   .rstn(rstn),
   .chip_init_pin_n(chip_init_pin_n),
   .insn_boundary(insn_boundary),
   .insn_done(insn_done),
   .exc_ack(exc_ack),
   .cpu_reset_q(cpu_reset_q),
   .ccr_i_q(ccr_i_q),
   .exc_q(exc_q)
);

// *** tb/reiu_cpu_model.sv ***
// cpu core model: takes exceptions, retires, writes the mask bit
`timescale 1ns/1ps
module reiu_cpu_model import reiu_pkg::*; (
   input wire logic clk,           // system clock
   input wire logic rstn,          // async reset, active low
   input wire reiu_exc_s exc_q,    // exception request
   input wire logic ccr_i_q,       // mask bit
   input wire logic hold_off,      // stay inside a long instruction
   input wire logic unmask,        // software wants interrupts
   input wire logic [3:0] ack_dly, // cycles before taking a request
   output logic insn_boundary,     // between instructions
   output logic insn_done,         // instruction retired
   output logic exc_ack,           // exception taken
   output logic ccr_i_we,          // mask bit write
   output logic ccr_i_wdata        // mask bit value
);
   assign insn_boundary = !hold_off;
   initial begin
      insn_done = 1'b0;
      exc_ack = 1'b0;
      ccr_i_we = 1'b0;
      ccr_i_wdata = 1'b0;
   end
   // no abort on reset: a stale ack may land
   always begin
      @(posedge clk);
      if (rstn && exc_q.req) begin
         repeat (ack_dly) @(posedge clk);
         exc_ack <= 1'b1;
         @(posedge clk);
         exc_ack <= 1'b0;
         repeat (2) @(posedge clk);
         insn_done <= 1'b1;
         @(posedge clk);
         insn_done <= 1'b0;
      end else if (rstn && ccr_i_q == unmask) begin
         ccr_i_we <= 1'b1;
         ccr_i_wdata <= !unmask;
         @(posedge clk);
         ccr_i_we <= 1'b0;
      end
   end
endmodule : reiu_cpu_model

// *** tb/reiu_exc_unit_tb.sv ***
// self-checking bench for the exception unit
`timescale 1ns/1ps
`include "reiu_params.svh"
module reiu_exc_unit_tb;
   import reiu_pkg::*;
   localparam int RC = 8;
   logic clk, rstn, chip_init_pin_n, mode_select_pin, reg_wr, reg_rd;
   logic [4:0] edge_request_pin, pol;
   logic [7:0] wakeup_pin_n, reg_addr, reg_wdata, reg_rdata_q;
   logic cpu_reset_q, ccr_i_q, hold_off, unmask, insn_boundary;
   logic insn_done, exc_ack, ccr_i_we, ccr_i_wdata;
   logic [3:0] ack_dly;
   logic [31:0] seed;
   reiu_int_src_s int_src;
   reiu_exc_s exc_q;
   int n_errors, num_checks, n, v, i;

   reiu_exc_unit #(.RELEASE_CLOCKS(RC)) u_dut (.clk(clk), .rstn(rstn),
      .chip_init_pin_n(chip_init_pin_n), .mode_select_pin(mode_select_pin),
      .edge_request_pin(edge_request_pin), .wakeup_pin_n(wakeup_pin_n),
      .int_src(int_src), .insn_boundary(insn_boundary),
      .insn_done(insn_done), .exc_ack(exc_ack), .ccr_i_we(ccr_i_we),
      .ccr_i_wdata(ccr_i_wdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .cpu_reset_q(cpu_reset_q),
      .ccr_i_q(ccr_i_q), .exc_q(exc_q));
   reiu_cpu_model u_cpu (.clk(clk), .rstn(rstn), .exc_q(exc_q),
      .ccr_i_q(ccr_i_q), .hold_off(hold_off), .unmask(unmask),
      .ack_dly(ack_dly), .insn_boundary(insn_boundary),
      .insn_done(insn_done), .exc_ack(exc_ack), .ccr_i_we(ccr_i_we),
      .ccr_i_wdata(ccr_i_wdata));

   // ----------
   // helpers
   // ----------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      chk(reg_rdata_q, e);
   endtask : rd
   task automatic wait_req(input logic lvl);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (exc_q.req !== lvl && n < 300);
      if (n == 300) chk(exc_q.req, lvl);
   endtask : wait_req
   // edges until reset is seen released
   task automatic count_release();
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (cpu_reset_q !== 1'b0 && n < 20000);
   endtask : count_release
   function automatic logic [19:0] gmask(input int vec);
      case (vec)
         10: gmask = 20'h80000;
         11: gmask = 20'h40000;
         12: gmask = 20'h20000;
         13: gmask = 20'h10000;
         14: gmask = 20'h0C000;
         15: gmask = 20'h03000;
         16: gmask = 20'h00C00;
         17: gmask = 20'h00300;
         18: gmask = 20'h000FC;
         19: gmask = 20'h00002;
         default: gmask = 20'h00001;
      endcase
   endfunction : gmask
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   // ----------
   // clock and watchdog
   // ----------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // about 500 cycles needed; twenty times that
   initial begin
      #100000;
      n_errors++;
      print_verdict();
   end

   // ----------
   // main sequence
   // ----------
   initial begin
      seed = 32'hA744;
      rstn = 1'b0;
      chip_init_pin_n = 1'b0;
      mode_select_pin = 1'b0;
      edge_request_pin = 5'h1F;
      wakeup_pin_n = 8'hFF;
      int_src = '0;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      {hold_off, unmask, ack_dly} = '0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (12) @(posedge clk);
      chip_init_pin_n <= 1'b1;
      repeat (20) @(posedge clk);
      chk(cpu_reset_q, 1'b1);
      mode_select_pin <= 1'b1;
      count_release();
      chk(n >= RC + 2 && n <= RC + 9, 1'b1);
      chk(exc_q, {1'b1, 5'h00, 16'h0000});
      chk(ccr_i_q, 1'b1);
      repeat (10) @(posedge clk);
      pol = 5'($random(seed));
      wr(`REIU_OFS_EDGE_SEL, {3'h0, pol});
      rd(`REIU_OFS_EDGE_SEL, {`REIU_EDGE_SEL_FIXED, pol});
      rd(8'h00, 8'h00);
      wr(`REIU_OFS_ENABLE1, 8'hFF);
      wr(`REIU_OFS_ENABLE2, 8'hFF);
      edge_request_pin <= ~pol;
      repeat (10) @(posedge clk);
      wr(`REIU_OFS_REQUEST1, 8'h00);
      wr(`REIU_OFS_WAKE_REQ, 8'h00);
      rd(`REIU_OFS_REQUEST1, {`REIU_REQUEST1_FIXED, 5'h00});
      // every source pending at once, cpu inside a long instruction
      {hold_off, unmask, ack_dly} <= {1'b1, 1'b1, 4'h8};
      edge_request_pin <= pol;
      wakeup_pin_n <= 8'h00;
      int_src <= reiu_int_src_s'(20'($random(seed)) | 20'hF5507);
      repeat (20) @(posedge clk);
      chk(exc_q.req, 1'b0);
      rd(`REIU_OFS_REQUEST1, {`REIU_REQUEST1_FIXED, 5'h1F});
      rd(`REIU_OFS_WAKE_REQ, 8'hFF);
      rd(`REIU_OFS_REQUEST2, 8'hFF);
      hold_off <= 1'b0;
      for (v = 4; v <= 20; v++) begin
         wait_req(1'b1);
         chk(exc_q.num, v);
         chk(exc_q.addr, 2 * v);
         if (v < 9) begin
            wr(`REIU_OFS_REQUEST1, ~(8'h01 << (v - 4)));
         end else if (v == 9) begin
            wr(`REIU_OFS_WAKE_REQ, 8'h00);
         end else begin
            int_src <= reiu_int_src_s'(int_src & ~gmask(v));
         end
         wait_req(1'b0);
      end
      rd(`REIU_OFS_REQUEST1, {`REIU_REQUEST1_FIXED, 5'h00});
      edge_request_pin <= ~pol;
      repeat (10) @(posedge clk);
      rd(`REIU_OFS_REQUEST1, {`REIU_REQUEST1_FIXED, 5'h00});
      // masked: flag sets, no acceptance
      unmask <= 1'b0;
      wakeup_pin_n <= 8'hFF;
      repeat (10) @(posedge clk);
      i = $unsigned($random(seed)) % 8;
      wakeup_pin_n <= ~(8'h01 << i);
      repeat (20) @(posedge clk);
      chk(exc_q.req, 1'b0);
      rd(`REIU_OFS_WAKE_REQ, 8'h01 << i);
      unmask <= 1'b1;
      wait_req(1'b1);
      chk(exc_q.num, 5'h09);
      wr(`REIU_OFS_WAKE_REQ, 8'h00);
      wait_req(1'b0);
      // init pin pulled while a request is outstanding
      ack_dly <= 4'hF;
      int_src <= reiu_int_src_s'(20'h00002);
      wait_req(1'b1);
      chip_init_pin_n <= 1'b0;
      repeat (14) @(posedge clk);
      chk(cpu_reset_q, 1'b1);
      chk(exc_q.req, 1'b0);
      int_src <= '0;
      chip_init_pin_n <= 1'b1;
      count_release();
      chk(n <= 9, 1'b1);
      chk(exc_q, {1'b1, 5'h00, 16'h0000});
      repeat (8) @(posedge clk);
      rd(`REIU_OFS_ENABLE1, `REIU_EN_RESET);
      print_verdict();
   end
endmodule : reiu_exc_unit_tb
